// >>> logic/window_monitor_pkg.sv
// Shared constants for the analog window monitor
package window_monitor_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_GAIN = 8'h00;
	localparam logic [7:0] OFS_SHIFT = 8'h04;
	localparam logic [7:0] OFS_UPPER = 8'h08;
	localparam logic [7:0] OFS_LOWER = 8'h0C;
	localparam logic [7:0] OFS_MSRC = 8'h10;
	localparam logic [7:0] OFS_CONFIG = 8'h14;
	localparam logic [7:0] OFS_REF = 8'h18;
	localparam logic [7:0] OFS_LIVE = 8'h1C;
	localparam logic [7:0] OFS_STATE = 8'h20;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
	// Field widths
	localparam int SAMPLE_W = 16;
	localparam int GAIN_W = 12;
	localparam int SHIFT_W = 16;
	localparam int MARGIN_W = 15;
	localparam int IRQ_W = 3;
	// Field positions
	localparam int MSRC_UP_SEL_BIT = 0;
	localparam int MSRC_LO_SEL_BIT = 1;
	localparam int MSRC_UP_NUM_LSB = 8;
	localparam int MSRC_LO_NUM_LSB = 16;
	localparam int CFG_DEC_LSB = 0;
	localparam int CFG_RET_BIT = 4;
	localparam int IRQ_FAULT_SET_BIT = 0;
	localparam int IRQ_FAULT_CLR_BIT = 1;
	localparam int IRQ_CAPTURE_BIT = 2;
	localparam int STATE_FAULT_BIT = 0;
	localparam int STATE_ARM_BIT = 1;
	localparam int STATE_REF_BIT = 2;
	// Limits; gain is in hundredths
	localparam logic signed [31:0] GAIN_LIMIT = 32'sh000003E8;
	localparam logic signed [31:0] SHIFT_LIMIT = 32'sh00002710;
	localparam logic signed [31:0] MARGIN_LIMIT = 32'sh00004E20;
	localparam logic signed [31:0] GAIN_DIVISOR = 32'sh00000064;
	// Reset values
	localparam logic [GAIN_W-1:0] GAIN_RESET = 12'h064;
	localparam logic [SHIFT_W-1:0] SHIFT_RESET = 16'h0000;
	localparam logic [MARGIN_W-1:0] MARGIN_RESET = 15'h0000;
	localparam logic [1:0] DEC_RESET = 2'h0;
endpackage : window_monitor_pkg

// >>> logic/value_scaler.sv
// Gain and zero shift applied to one analog value
`timescale 1ns/10ps
module value_scaler (
	input wire logic signed [window_monitor_pkg::SAMPLE_W-1:0] value,
	input wire logic signed [window_monitor_pkg::GAIN_W-1:0] gain,
	input wire logic signed [window_monitor_pkg::SHIFT_W-1:0] shift,
	output logic signed [31:0] scaled
);
	logic signed [31:0] value_ext;
	logic signed [31:0] gain_ext;
	logic signed [31:0] product;
	logic signed [31:0] quotient;

	// Multiply first, then add; 32 bits cannot overflow for clamped inputs
	assign value_ext = 32'(value);
	assign gain_ext = 32'(gain);
	assign product = value_ext * gain_ext;
	assign quotient = product / window_monitor_pkg::GAIN_DIVISOR; // Truncates toward zero
	assign scaled = quotient + 32'(shift);
endmodule : value_scaler

// >>> logic/analog_window_monitor.sv
// Analog window monitor with APB registers and interrupt
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module analog_window_monitor #(
	parameter int NUM_BLOCKS = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic arm_in,
	input wire logic signed [window_monitor_pkg::SAMPLE_W-1:0] analog_sample_in,
	input wire logic [NUM_BLOCKS*window_monitor_pkg::SAMPLE_W-1:0] block_value_in,
	input wire logic restart_in,
	output logic fault_out,
	output logic irq
);
	localparam int SW = window_monitor_pkg::SAMPLE_W;
	localparam int NUM_W = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1;

	// Software-visible settings
	logic signed [window_monitor_pkg::GAIN_W-1:0] gain;
	logic signed [window_monitor_pkg::SHIFT_W-1:0] shift;
	logic [window_monitor_pkg::MARGIN_W-1:0] upper_const;
	logic [window_monitor_pkg::MARGIN_W-1:0] lower_const;
	logic upper_from_block;
	logic lower_from_block;
	logic [NUM_W-1:0] upper_block;
	logic [NUM_W-1:0] lower_block;
	logic [1:0] decimals;
	logic retentive;
	logic [window_monitor_pkg::IRQ_W-1:0] irq_status;
	logic [window_monitor_pkg::IRQ_W-1:0] irq_mask;

	// Monitoring state
	logic arm_prev;
	logic signed [SW-1:0] ref_raw;
	logic ref_valid;
	logic restart_clear;

	// Bus decode
	logic setup_phase;
	logic wr_strobe;
	logic addr_ok;
	logic [31:0] next_prdata;

	// Datapath
	logic arm_rise;
	logic signed [31:0] live_scaled;
	logic signed [31:0] ref_scaled;
	logic [window_monitor_pkg::MARGIN_W-1:0] upper_margin;
	logic [window_monitor_pkg::MARGIN_W-1:0] lower_margin;
	logic signed [33:0] win_hi;
	logic signed [33:0] win_lo;
	logic signed [33:0] live_wide;
	logic outside;
	logic [window_monitor_pkg::IRQ_W-1:0] irq_events;
	logic signed [SW-1:0] block_value [NUM_BLOCKS];

	// Saturate a signed write to a symmetric limit
	function automatic logic signed [31:0] sat_sym(input logic signed [31:0] v,
		input logic signed [31:0] lim);
		logic signed [31:0] r;
		r = v;
		if (v > lim) begin
			r = lim;
		end else if (v < -lim) begin
			r = -lim;
		end
		return r;
	endfunction : sat_sym

	// Saturate a margin to the legal non-negative span
	function automatic logic [window_monitor_pkg::MARGIN_W-1:0] sat_margin(
		input logic signed [31:0] v);
		logic signed [31:0] r;
		r = v;
		if (v < 0) begin
			r = 32'sh00000000;
		end else if (v > window_monitor_pkg::MARGIN_LIMIT) begin
			r = window_monitor_pkg::MARGIN_LIMIT;
		end
		return r[window_monitor_pkg::MARGIN_W-1:0];
	endfunction : sat_margin

	// APB handshake: zero wait while clk_en is high, data latched during setup so prdata is a flop
	assign setup_phase = psel & ~penable;
	assign wr_strobe = psel & penable & pwrite & clk_en;
	assign pready = psel & penable & clk_en;

	// Full decode, so holes in the map answer with an error
	assign addr_ok = (paddr == window_monitor_pkg::OFS_GAIN)
		|| (paddr == window_monitor_pkg::OFS_SHIFT)
		|| (paddr == window_monitor_pkg::OFS_UPPER)
		|| (paddr == window_monitor_pkg::OFS_LOWER)
		|| (paddr == window_monitor_pkg::OFS_MSRC)
		|| (paddr == window_monitor_pkg::OFS_CONFIG)
		|| (paddr == window_monitor_pkg::OFS_REF)
		|| (paddr == window_monitor_pkg::OFS_LIVE)
		|| (paddr == window_monitor_pkg::OFS_STATE)
		|| (paddr == window_monitor_pkg::OFS_IRQ_STAT)
		|| (paddr == window_monitor_pkg::OFS_IRQ_MASK);
	assign pslverr = pready & ~addr_ok; // Unmapped addresses error, read zero

	// Read multiplexer
	always_comb begin
		next_prdata = 32'h00000000;
		unique case (paddr)
			window_monitor_pkg::OFS_GAIN: next_prdata = 32'(gain);
			window_monitor_pkg::OFS_SHIFT: next_prdata = 32'(shift);
			window_monitor_pkg::OFS_UPPER: next_prdata = {17'h00000, upper_const};
			window_monitor_pkg::OFS_LOWER: next_prdata = {17'h00000, lower_const};
			window_monitor_pkg::OFS_MSRC: begin
				next_prdata[window_monitor_pkg::MSRC_UP_SEL_BIT] = upper_from_block;
				next_prdata[window_monitor_pkg::MSRC_LO_SEL_BIT] = lower_from_block;
				next_prdata[window_monitor_pkg::MSRC_UP_NUM_LSB +: NUM_W] = upper_block;
				next_prdata[window_monitor_pkg::MSRC_LO_NUM_LSB +: NUM_W] = lower_block;
			end
			window_monitor_pkg::OFS_CONFIG: begin
				next_prdata[window_monitor_pkg::CFG_DEC_LSB +: 2] = decimals;
				next_prdata[window_monitor_pkg::CFG_RET_BIT] = retentive;
			end
			window_monitor_pkg::OFS_REF: next_prdata = ref_scaled;
			window_monitor_pkg::OFS_LIVE: next_prdata = live_scaled;
			window_monitor_pkg::OFS_STATE: begin
				next_prdata[window_monitor_pkg::STATE_FAULT_BIT] = fault_out;
				next_prdata[window_monitor_pkg::STATE_ARM_BIT] = arm_prev;
				next_prdata[window_monitor_pkg::STATE_REF_BIT] = ref_valid;
			end
			window_monitor_pkg::OFS_IRQ_STAT: next_prdata = 32'(irq_status);
			window_monitor_pkg::OFS_IRQ_MASK: next_prdata = 32'(irq_mask);
			default: next_prdata = 32'h00000000;
		endcase
	end

	// Read data register, loaded in the setup cycle
	// Reads of live values therefore show the setup-cycle sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (clk_en && setup_phase) begin
			prdata <= pwrite ? 32'h00000000 : next_prdata;
		end
	end

	// Scaling settings, clamped to their legal spans on write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain <= window_monitor_pkg::GAIN_RESET;
			shift <= window_monitor_pkg::SHIFT_RESET;
		end else if (wr_strobe) begin
			if (paddr == window_monitor_pkg::OFS_GAIN) begin
				gain <= window_monitor_pkg::GAIN_W'(sat_sym($signed(pwdata),
					window_monitor_pkg::GAIN_LIMIT));
			end
			if (paddr == window_monitor_pkg::OFS_SHIFT) begin
				shift <= window_monitor_pkg::SHIFT_W'(sat_sym($signed(pwdata),
					window_monitor_pkg::SHIFT_LIMIT));
			end
		end
	end

	// Constant margins, each written on its own
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_const <= window_monitor_pkg::MARGIN_RESET;
			lower_const <= window_monitor_pkg::MARGIN_RESET;
		end else if (wr_strobe) begin
			if (paddr == window_monitor_pkg::OFS_UPPER) begin
				upper_const <= sat_margin($signed(pwdata));
			end
			if (paddr == window_monitor_pkg::OFS_LOWER) begin
				lower_const <= sat_margin($signed(pwdata));
			end
		end
	end

	// Margin source selection and block numbers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_from_block <= 1'b0;
			lower_from_block <= 1'b0;
			upper_block <= '0;
			lower_block <= '0;
		end else if (wr_strobe && paddr == window_monitor_pkg::OFS_MSRC) begin
			upper_from_block <= pwdata[window_monitor_pkg::MSRC_UP_SEL_BIT];
			lower_from_block <= pwdata[window_monitor_pkg::MSRC_LO_SEL_BIT];
			upper_block <= pwdata[window_monitor_pkg::MSRC_UP_NUM_LSB +: NUM_W];
			lower_block <= pwdata[window_monitor_pkg::MSRC_LO_NUM_LSB +: NUM_W];
		end
	end

	// Display decimals are only stored for readback
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			decimals <= window_monitor_pkg::DEC_RESET;
			retentive <= 1'b0;
		end else if (wr_strobe && paddr == window_monitor_pkg::OFS_CONFIG) begin
			decimals <= pwdata[window_monitor_pkg::CFG_DEC_LSB +: 2];
			retentive <= pwdata[window_monitor_pkg::CFG_RET_BIT];
		end
	end

	// Live and reference pass through the same scaling
	value_scaler u_live_scaler (
		.value(analog_sample_in),
		.gain(gain),
		.shift(shift),
		.scaled(live_scaled)
	);

	// Reference rescaled with current gain, so a gain change moves the window
	value_scaler u_ref_scaler (
		.value(ref_raw),
		.gain(gain),
		.shift(shift),
		.scaled(ref_scaled)
	);

	// Unpack neighbour values once so each margin mux indexes an array
	for (genvar k = 0; k < NUM_BLOCKS; k++) begin : g_block
		assign block_value[k] = block_value_in[k*SW +: SW];
	end

	// Margins follow a block's live value when selected; out-of-range values saturate
	// A block number past the last block falls back to the constant
	always_comb begin
		upper_margin = upper_const;
		lower_margin = lower_const;
		if (upper_from_block && int'(upper_block) < NUM_BLOCKS) begin
			upper_margin = sat_margin(32'(block_value[upper_block]));
		end
		if (lower_from_block && int'(lower_block) < NUM_BLOCKS) begin
			lower_margin = sat_margin(32'(block_value[lower_block]));
		end
	end

	// Window bounds in 34 bits so no sum can wrap
	assign win_hi = 34'(ref_scaled) + 34'($signed({1'b0, upper_margin}));
	assign win_lo = 34'(ref_scaled) - 34'($signed({1'b0, lower_margin}));

	// Equal to a bound counts as inside
	assign live_wide = 34'(live_scaled);
	assign outside = (live_wide > win_hi) || (live_wide < win_lo);

	// Rising edge of the arm input; decimals take no part in this path
	assign arm_rise = arm_in & ~arm_prev;

	// Power restore wipes state unless the retentive option is set
	assign restart_clear = restart_in & ~retentive;

	// Arm history and captured reference; a restart clears them unless retentive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_prev <= 1'b0;
			ref_raw <= '0;
			ref_valid <= 1'b0;
		end else if (clk_en) begin
			if (restart_clear) begin
				arm_prev <= 1'b0;
				ref_raw <= '0;
				ref_valid <= 1'b0;
			end else begin
				arm_prev <= arm_in;
				if (arm_rise) begin
					ref_raw <= analog_sample_in;
					ref_valid <= 1'b1;
				end
			end
		end
	end

	// Fault output, one cycle after its cause; cleared on the capture cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_out <= 1'b0;
		end else if (clk_en) begin
			if (restart_clear) begin
				fault_out <= 1'b0;
			end else if (!arm_in || arm_rise || !ref_valid) begin
				fault_out <= 1'b0;
			end else begin
				fault_out <= outside;
			end
		end
	end

	// Events: fault set, fault cleared, reference captured
	always_comb begin
		irq_events = '0;
		irq_events[window_monitor_pkg::IRQ_FAULT_SET_BIT] = clk_en & ~fault_out & arm_in
			& ~arm_rise & ref_valid & outside & ~restart_clear;
		irq_events[window_monitor_pkg::IRQ_FAULT_CLR_BIT] = clk_en & fault_out
			& (~arm_in | ~outside | restart_clear);
		irq_events[window_monitor_pkg::IRQ_CAPTURE_BIT] = clk_en & arm_rise
			& ~restart_clear;
	end

	// Sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
		end else if (clk_en) begin
			if (wr_strobe && paddr == window_monitor_pkg::OFS_IRQ_STAT) begin
				irq_status <= (irq_status & ~pwdata[window_monitor_pkg::IRQ_W-1:0]) | irq_events;
			end else begin
				irq_status <= irq_status | irq_events;
			end
		end
	end

	// Interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= '0;
		end else if (wr_strobe && paddr == window_monitor_pkg::OFS_IRQ_MASK) begin
			irq_mask <= pwdata[window_monitor_pkg::IRQ_W-1:0];
		end
	end

	// Level interrupt while any unmasked status bit stands
	assign irq = |(irq_status & irq_mask);
endmodule : analog_window_monitor

// >>> tb/window_monitor_checker.sv
// Port-level assertions for the analog window monitor
`timescale 1ns/10ps
module window_monitor_checker #(
	parameter int NUM_BLOCKS = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic arm_in,
	input wire logic signed [window_monitor_pkg::SAMPLE_W-1:0] analog_sample_in,
	input wire logic [NUM_BLOCKS*window_monitor_pkg::SAMPLE_W-1:0] block_value_in,
	input wire logic restart_in,
	input wire logic fault_out,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Fault output against arm and sample
	property p_arm_low; clk_en && !arm_in |=> !fault_out; endproperty
	a_arm_low: assert property (p_arm_low) else $error("fault high after arm low");
	property p_arm_rise; clk_en && $rose(arm_in) |=> !fault_out; endproperty
	a_arm_rise: assert property (p_arm_rise) else $error("fault high on capture");
	property p_cause; $rose(fault_out) |-> $past(arm_in) && $past(clk_en); endproperty
	a_cause: assert property (p_cause) else $error("fault rose while unarmed");
	// Past write would move the window, so steady means no bus access either
	property p_hold;
		fault_out && arm_in && $stable(arm_in) && clk_en && $past(clk_en) && !restart_in &&
		$stable(analog_sample_in) && $stable(block_value_in) && !penable && !$past(penable)
		|=> fault_out;
	endproperty
	a_hold: assert property (p_hold) else $error("fault dropped with steady inputs");
	property p_freeze; !clk_en |=> $stable(fault_out) && $stable(prdata); endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");
	// Bus answers
	property p_ready; psel && penable |-> pready == clk_en; endproperty
	a_ready: assert property (p_ready) else $error("pready wrong");
	property p_err;
		psel && penable && clk_en |-> pslverr == (paddr > 8'h28 || paddr[1:0] != 2'h0);
	endproperty
	a_err: assert property (p_err) else $error("pslverr wrong");
	property p_rd_hold; !psel |=> $stable(prdata); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("prdata moved while idle");
	c_fault_irq: cover property (fault_out && irq);
	c_fall: cover property ($fell(fault_out) && arm_in);
	c_err: cover property (pslverr);
endmodule : window_monitor_checker

// >>> tb/analog_source_model.sv
// Far-side sources: one physical channel and the neighbour blocks
`timescale 1ns/10ps
module analog_source_model (
	input wire logic signed [15:0] want,
	input wire logic [127:0] blocks_want,
	output logic signed [window_monitor_pkg::SAMPLE_W-1:0] analog_sample_in,
	output logic [127:0] block_value_in
);
	// Physical channel clipped to its full-scale span
	assign analog_sample_in = want < 0 ? 16'sh0000 : want > 16'sh03E8 ? 16'sh03E8 : want;
	assign block_value_in = blocks_want;
endmodule : analog_source_model

// >>> tb/tb_analog_window_monitor.sv
// Random self-checking bench for the analog window monitor
`timescale 1ns/10ps
module tb_analog_window_monitor;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
	logic arm_in, restart_in, fault_out, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic signed [15:0] want, analog_sample_in;
	logic [127:0] blocks, block_value_in;
	int miscompares, n_tests, g, s, up, lo, r, x;
	analog_window_monitor #(.NUM_BLOCKS(8)) dut (.pclk(pclk), .presetn(presetn),
		.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .arm_in(arm_in),
		.analog_sample_in(analog_sample_in), .block_value_in(block_value_in),
		.restart_in(restart_in), .fault_out(fault_out), .irq(irq));
	analog_source_model src (.want(want), .blocks_want(blocks),
		.analog_sample_in(analog_sample_in), .block_value_in(block_value_in));
	// Bus clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// Fixed-seed shift register draws
	function automatic int rnd(input int m);
		for (int i = 0; i < 8; i++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return int'(seed[15:0]) % m;
	endfunction : rnd
	function automatic int scl(input int v);
		return v * g / 100 + s;
	endfunction : scl
	// Bounds themselves count as inside
	function automatic int outside(input int rv, input int v);
		return int'(scl(v) > scl(rv) + up || scl(v) < scl(rv) - lo);
	endfunction : outside
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// One transfer, request held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic two;
		repeat (2) @(posedge pclk);
	endtask : two
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test
	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		#100000;
		miscompares++;
		stop_test();
	end
	initial begin
		seed = 32'h000155EE;
		{presetn, clk_en, psel, penable, pwrite, arm_in, restart_in} = 7'h20;
		paddr = 8'h00;
		pwdata = 32'h0;
		want = 16'sh0000;
		blocks = 128'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, window_monitor_pkg::OFS_GAIN, 0);
		chk("gain reset", 32'h64, rd);
		apb(1'b1, window_monitor_pkg::OFS_GAIN, 32'h7D0);
		apb(1'b0, window_monitor_pkg::OFS_GAIN, 0);
		chk("gain limit", 32'h3E8, rd);
		apb(1'b1, window_monitor_pkg::OFS_SHIFT, 32'hFFFFB1E0);
		apb(1'b0, window_monitor_pkg::OFS_SHIFT, 0);
		chk("shift limit", 32'hFFFFD8F0, rd);
		apb(1'b1, window_monitor_pkg::OFS_UPPER, 32'h7530);
		apb(1'b1, window_monitor_pkg::OFS_LOWER, 32'h5);
		apb(1'b0, window_monitor_pkg::OFS_UPPER, 0);
		chk("upper limit", 32'h4E20, rd);
		apb(1'b0, 8'h2C, 0);
		chk("unmapped err", 1, err);
		chk("unmapped data", 0, rd);
		// Random windows; odd trials take both margins from neighbour blocks
		for (int t = 0; t < 12; t++) begin
			g = rnd(2001) - 1000;
			s = rnd(20001) - 10000;
			up = t == 0 ? 0 : rnd(3000);
			lo = t == 0 ? 0 : rnd(3000);
			r = rnd(8);
			for (int b = 0; b < 8; b++) blocks[b*16 +: 16] <= 16'(rnd(3000));
			apb(1'b1, window_monitor_pkg::OFS_GAIN, 32'(g));
			apb(1'b1, window_monitor_pkg::OFS_SHIFT, 32'(s));
			apb(1'b1, window_monitor_pkg::OFS_UPPER, 32'(up));
			apb(1'b1, window_monitor_pkg::OFS_LOWER, 32'(lo));
			apb(1'b1, window_monitor_pkg::OFS_MSRC, 32'(t % 2 * (3 | r << 8 | (r + 1) % 8 << 16)));
			apb(1'b1, window_monitor_pkg::OFS_CONFIG, 32'(rnd(4)));
			if (t % 2) begin
				up = blocks[r*16 +: 16];
				lo = blocks[(r + 1) % 8 * 16 +: 16];
			end
			r = rnd(1001);
			arm_in <= 1'b1;
			want <= 16'(r);
			two();
			chk("fault at capture", 0, fault_out);
			repeat (6) begin
				x = rnd(1001);
				want <= 16'(x);
				two();
				chk("fault", outside(r, x), fault_out);
			end
			apb(1'b0, window_monitor_pkg::OFS_REF, 0);
			chk("reference", 32'(scl(r)), rd);
			arm_in <= 1'b0;
			two();
			chk("fault unarmed", 0, fault_out);
		end
		// Interrupt, bounds, freeze and restart on a unity-gain window of 500 +-10
		apb(1'b1, window_monitor_pkg::OFS_GAIN, 32'h64);
		apb(1'b1, window_monitor_pkg::OFS_SHIFT, 0);
		apb(1'b1, window_monitor_pkg::OFS_MSRC, 0);
		apb(1'b1, window_monitor_pkg::OFS_UPPER, 32'hA);
		apb(1'b1, window_monitor_pkg::OFS_LOWER, 32'hA);
		apb(1'b1, window_monitor_pkg::OFS_IRQ_MASK, 32'h1);
		apb(1'b1, window_monitor_pkg::OFS_IRQ_STAT, 32'h7);
		arm_in <= 1'b1;
		want <= 16'sh01F4;
		two();
		chk("masked irq", 0, irq);
		want <= 16'sh01FE;
		two();
		chk("upper bound", 0, fault_out);
		want <= 16'sh01EA;
		two();
		chk("lower bound", 0, fault_out);
		want <= 16'sh0258;
		two();
		chk("fault", 1, fault_out);
		chk("irq", 1, irq);
		apb(1'b0, window_monitor_pkg::OFS_LIVE, 0);
		chk("live scaled", 32'h258, rd);
		apb(1'b0, window_monitor_pkg::OFS_IRQ_STAT, 0);
		chk("status", 32'h5, rd);
		apb(1'b1, window_monitor_pkg::OFS_IRQ_STAT, 32'h1);
		chk("irq cleared", 0, irq);
		clk_en <= 1'b0;
		want <= 16'sh01F4;
		two();
		chk("frozen", 1, fault_out);
		clk_en <= 1'b1;
		want <= 16'sh0258;
		for (int k = 1; k >= 0; k--) begin
			apb(1'b1, window_monitor_pkg::OFS_CONFIG, 32'(k * 16));
			restart_in <= 1'b1;
			@(posedge pclk);
			restart_in <= 1'b0;
			@(posedge pclk);
			chk("after restart", 32'(k), fault_out);
		end
		// Restart without retention dropped the fault and forced a fresh capture
		apb(1'b0, window_monitor_pkg::OFS_STATE, 0);
		chk("state", 32'h6, rd);
		apb(1'b0, window_monitor_pkg::OFS_IRQ_STAT, 0);
		chk("status after restart", 32'h6, rd);
		chk("irq masked", 0, irq);
		stop_test();
	end
endmodule : tb_analog_window_monitor
bind analog_window_monitor window_monitor_checker #(.NUM_BLOCKS(NUM_BLOCKS)) chk_i (
	.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .arm_in(arm_in),
	.analog_sample_in(analog_sample_in), .block_value_in(block_value_in),
	.restart_in(restart_in), .fault_out(fault_out), .irq(irq));
